// ### rtl/clock_gate_lane.sv
`timescale 1ns/1ps
`default_nettype none

// One bank of peripheral clock enables, steered by the next mode
module clock_gate_lane
  import pmc_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  mode_flags_if.lane flags,
  input wire logic [GATE_WIDTH-1:0] gate_bits,
  output logic [GATE_WIDTH-1:0] clk_en_r
);

  // Stop halts all, low-power modes follow the gating bits
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      clk_en_r <= GATE_RESET;
    end else if (flags.stop_next) begin
      clk_en_r <= '0;
    end else if (flags.lp_next) begin
      clk_en_r <= gate_bits;
    end else begin
      clk_en_r <= GATE_RESET;
    end
  end

endmodule

`default_nettype wire

// ### rtl/mode_flags_if.sv
`timescale 1ns/1ps
`default_nettype none

// Next-mode summary handed from the sequencer to the clock gating lanes
interface mode_flags_if;
  logic stop_next; // Next mode is either stop mode
  logic lp_next; // Next mode is low-power run or low-power wait
  modport ctrl (output stop_next, output lp_next);
  modport lane (input stop_next, input lp_next);
endinterface

`default_nettype wire

// ### rtl/pmc_pkg.sv
package pmc_pkg;

  // Operating modes of the device
  typedef enum logic [2:0] {
    MODE_RUN    = 3'b000,
    MODE_WAIT   = 3'b001,
    MODE_REDUCED_POWER_RUN_MODE  = 3'b010,
    MODE_REDUCED_POWER_WAIT_MODE = 3'b011,
    MODE_SHALLOW_STOP_MODE  = 3'b100,
    MODE_DEEPEST_STOP_MODE  = 3'b101
  } power_mode_type;

  // Regulator state codes
  localparam logic [1:0] REG_FULL_ON = 2'h0;
  localparam logic [1:0] REG_STANDBY = 2'h1;
  localparam logic [1:0] REG_PARTIAL_DOWN = 2'h2;

  // Width of each clock gating register
  localparam int GATE_WIDTH = 8;

  // Reset values
  localparam power_mode_type MODE_RESET = MODE_RUN;
  localparam logic LPR_RESET = 1'b0;
  localparam logic DEEP_RESET = 1'b0;
  localparam logic DEBUG_RESET = 1'b0;
  localparam logic PIN_IDLE = 1'b1;
  localparam logic [GATE_WIDTH-1:0] GATE_RESET = 8'hff;
  localparam logic [1:0] REG_RESET = REG_FULL_ON;

endpackage

// ### rtl/power_mode_controller.sv
// Notes on behaviour
// - Interrupts end shallow stop and wait modes
// - Deepest stop entered from run by stop
// - Deepest stop wake starts full power-on reset
// - Shallow stop exit to run conditions
// - Stop modes halt all peripheral clocks
// - Low-power modes gate clocks per bits
// - Debug enabled turns deepest stop into shallow
// - Stop voltage detect turns deepest into shallow
// - Debug enabled blocks low-power run and wait
// - Stop voltage detect blocks low-power modes
// - Debug bit written only by debug port
// - Deepest stop powers down all but counter
// - Shallow stop clock generator on when enabled
// - Stop external oscillator on when enabled
// - Shallow stop regulator full when detect on
// - Converter uses async clock in low modes
// - No bandgap conversion in low-power modes
// - Wake-to-run stop exit clears low-power bits
// - Deep stop and low-power run exclusive
// - Deepest stop never entered from low-power run
`timescale 1ns/1ps
`default_nettype none

module power_mode_controller
  import pmc_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  // Core events, same clock, one-cycle pulses
  input wire logic stop_instr,
  input wire logic wait_instr,
  input wire logic interrupt_req,
  // Shared reset-capable wake pin, asynchronous, active low
  input wire logic shared_reset_wake_pin_n,
  // Software control bit writes
  input wire logic lpr_write,
  input wire logic lpr_write_data,
  input wire logic deep_stop_write,
  input wire logic deep_stop_write_data,
  input wire logic wake_to_full_run_select,
  // Debug port command writes
  input wire logic background_debug_port_write,
  input wire logic background_debug_port_data,
  // Supply monitor configuration
  input wire logic voltage_detect_enable,
  input wire logic voltage_detect_in_stop_enable,
  // Clock generator configuration
  input wire logic internal_clock_out_enable,
  input wire logic internal_ref_stop_enable,
  input wire logic external_clock_out_enable,
  input wire logic external_ref_stop_enable,
  input wire logic [GATE_WIDTH-1:0] clock_gating_reg_one,
  input wire logic [GATE_WIDTH-1:0] clock_gating_reg_two,
  // Converter configuration
  input wire logic adc_async_clock_select,
  input wire logic adc_bandgap_select,
  // Mode and status
  output logic [2:0] mode_code_r,
  output logic low_power_run_request_r,
  output logic low_power_run_state_flag_r,
  output logic deep_stop_select_r,
  output logic debug_mode_enable_r,
  // Clock and power controls
  output logic cpu_clk_en_r,
  output logic [GATE_WIDTH-1:0] periph_clk_en_one_r,
  output logic [GATE_WIDTH-1:0] periph_clk_en_two_r,
  output logic debug_clk_en_r,
  output logic [1:0] regulator_state_r,
  output logic clock_gen_on_r,
  output logic ext_osc_on_r,
  output logic core_power_on_r,
  output logic rtc_power_on_r,
  output logic por_start_r,
  output logic adc_run_permit_r,
  output logic adc_bandgap_block_r
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  power_mode_type mode_r; // Current mode
  power_mode_type mode_nxt; // Next mode
  logic lpr_r; // Low-power run request bit
  logic deep_r; // Deepest stop select bit
  logic debug_r; // Debug enable bit
  logic shallow_stop_mode_lp_r; // Shallow stop was entered from low-power run
  logic pin_sync_n; // Synchronised wake pin level
  logic pin_reset; // Wake pin held low
  logic lp_blocked; // Low-power modes and deepest stop forbidden
  logic lpr_clear; // Sequencer clears the low-power run bit
  logic next_is_stop; // Next mode is a stop mode
  logic next_is_lp; // Next mode is a low-power mode
  logic next_is_shallow_stop_mode; // Next mode is shallow stop
  mode_flags_if flags_bus (); // Carrier to the gating lanes

  ////////////////////////////////////////////////////////////////////////////
  // Wake pin synchroniser

  // Pin comes from outside the clock domain
  sync_two_stage u_pin_sync (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .async_in(shared_reset_wake_pin_n),
    .sync_out(pin_sync_n)
  );

  // A low pin acts as a reset request in every mode
  assign pin_reset = !pin_sync_n;

  // Debug or stop supply monitoring forces the fallback modes
  assign lp_blocked = debug_r | voltage_detect_in_stop_enable;

  ////////////////////////////////////////////////////////////////////////////
  // Mode transition logic

  // Chooses the next mode from the core events and control bits
  always_comb begin
    mode_nxt = mode_r;
    lpr_clear = 1'b0;
    if (pin_reset) begin
      // Pin reset returns every mode to run
      mode_nxt = MODE_RUN;
      lpr_clear = 1'b1;
    end else begin
      unique case (mode_r)
        MODE_RUN: begin
          if (stop_instr) begin
            // Deepest stop only when pre-selected and not forced shallow
            if (deep_r && !lp_blocked) begin
              mode_nxt = MODE_DEEPEST_STOP_MODE;
            end else begin
              mode_nxt = MODE_SHALLOW_STOP_MODE;
            end
          end else if (wait_instr) begin
            // Run only ever waits in normal wait
            mode_nxt = MODE_WAIT;
          end else if (lpr_r && !lp_blocked) begin
            // Bit written last by software moves to low-power run
            mode_nxt = MODE_REDUCED_POWER_RUN_MODE;
          end
        end
        MODE_WAIT: begin
          if (interrupt_req) begin
            mode_nxt = MODE_RUN;
          end
        end
        MODE_REDUCED_POWER_RUN_MODE: begin
          if (!lpr_r || lp_blocked) begin
            // Bit cleared, or debug or monitor now enabled
            mode_nxt = MODE_RUN;
          end else if (stop_instr) begin
            // Deepest stop is impossible from here
            mode_nxt = MODE_SHALLOW_STOP_MODE;
          end else if (wait_instr) begin
            mode_nxt = MODE_REDUCED_POWER_WAIT_MODE;
          end else if (interrupt_req && wake_to_full_run_select) begin
            mode_nxt = MODE_RUN;
            lpr_clear = 1'b1;
          end
        end
        MODE_REDUCED_POWER_WAIT_MODE: begin
          if (lp_blocked) begin
            // Forced out of low power into normal wait
            mode_nxt = MODE_WAIT;
          end else if (interrupt_req) begin
            if (wake_to_full_run_select) begin
              mode_nxt = MODE_RUN;
              lpr_clear = 1'b1;
            end else begin
              mode_nxt = MODE_REDUCED_POWER_RUN_MODE;
            end
          end
        end
        MODE_SHALLOW_STOP_MODE: begin
          if (interrupt_req) begin
            if (shallow_stop_mode_lp_r && !wake_to_full_run_select) begin
              mode_nxt = MODE_REDUCED_POWER_RUN_MODE;
            end else begin
              mode_nxt = MODE_RUN;
              lpr_clear = shallow_stop_mode_lp_r || wake_to_full_run_select;
            end
          end
        end
        MODE_DEEPEST_STOP_MODE: begin
          // Interrupts are ignored, only the pin wakes
          mode_nxt = MODE_DEEPEST_STOP_MODE;
        end
        default: begin
          mode_nxt = MODE_RUN;
        end
      endcase
    end
  end

  // Summaries of the next mode
  assign next_is_stop = (mode_nxt == MODE_DEEPEST_STOP_MODE) || (mode_nxt == MODE_SHALLOW_STOP_MODE);
  assign next_is_lp = (mode_nxt == MODE_REDUCED_POWER_RUN_MODE) || (mode_nxt == MODE_REDUCED_POWER_WAIT_MODE);
  assign next_is_shallow_stop_mode = (mode_nxt == MODE_SHALLOW_STOP_MODE);
  assign flags_bus.stop_next = next_is_stop;
  assign flags_bus.lp_next = next_is_lp;

  ////////////////////////////////////////////////////////////////////////////
  // State registers

  // Current mode
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      mode_r <= MODE_RESET;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  // Remembers whether shallow stop came from low-power run
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      shallow_stop_mode_lp_r <= 1'b0;
    end else if (mode_r != MODE_SHALLOW_STOP_MODE) begin
      shallow_stop_mode_lp_r <= (mode_r == MODE_REDUCED_POWER_RUN_MODE);
    end
  end

  // Low-power run bit, refused while deepest stop is selected
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      lpr_r <= LPR_RESET;
    end else if (lpr_clear) begin
      lpr_r <= 1'b0;
    end else if (lpr_write) begin
      if (!lpr_write_data) begin
        lpr_r <= 1'b0;
      // A deep stop select written in the same cycle wins
      end else if (!deep_r && !(deep_stop_write && deep_stop_write_data)) begin
        lpr_r <= 1'b1;
      end
    end
  end

  // Deepest stop select, refused while low-power run is requested
  always_ff @(posedge core_clk) begin
    if (!reset_n || pin_reset) begin
      deep_r <= DEEP_RESET;
    end else if (deep_stop_write) begin
      if (!deep_stop_write_data) begin
        deep_r <= 1'b0;
      end else if (!lpr_r) begin
        deep_r <= 1'b1;
      end
    end
  end

  // Debug enable, written only by debug port commands
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      debug_r <= DEBUG_RESET;
    end else if (mode_r == MODE_DEEPEST_STOP_MODE && pin_reset) begin
      debug_r <= DEBUG_RESET;
    end else if (background_debug_port_write) begin
      debug_r <= background_debug_port_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status outputs

  // Status mirrors: mode and low-power flag aligned with the current mode, bit mirrors one cycle behind their bits
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      mode_code_r <= MODE_RESET;
      low_power_run_state_flag_r <= 1'b0;
      low_power_run_request_r <= LPR_RESET;
      deep_stop_select_r <= DEEP_RESET;
      debug_mode_enable_r <= DEBUG_RESET;
    end else begin
      mode_code_r <= mode_nxt;
      low_power_run_state_flag_r <= next_is_lp;
      low_power_run_request_r <= lpr_r;
      deep_stop_select_r <= deep_r;
      debug_mode_enable_r <= debug_r;
    end
  end

  // Power-on reset start pulse on a deepest stop wake
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      por_start_r <= 1'b0;
    end else begin
      por_start_r <= (mode_r == MODE_DEEPEST_STOP_MODE) && pin_reset;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock and power controls

  // Core clock runs only in run and low-power run
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      cpu_clk_en_r <= 1'b1;
      debug_clk_en_r <= DEBUG_RESET;
    end else begin
      cpu_clk_en_r <= (mode_nxt == MODE_RUN) || (mode_nxt == MODE_REDUCED_POWER_RUN_MODE);
      debug_clk_en_r <= debug_r && (mode_nxt != MODE_DEEPEST_STOP_MODE);
    end
  end

  // Peripheral clock banks
  clock_gate_lane u_gate_one (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .flags(flags_bus.lane),
    .gate_bits(clock_gating_reg_one),
    .clk_en_r(periph_clk_en_one_r)
  );

  clock_gate_lane u_gate_two (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .flags(flags_bus.lane),
    .gate_bits(clock_gating_reg_two),
    .clk_en_r(periph_clk_en_two_r)
  );

  // Regulator: partial down in deepest stop, standby in low modes
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      regulator_state_r <= REG_RESET;
    end else if (mode_nxt == MODE_DEEPEST_STOP_MODE) begin
      regulator_state_r <= REG_PARTIAL_DOWN;
    end else if (next_is_shallow_stop_mode) begin
      // Supply monitor or debug keeps full regulation
      if ((voltage_detect_enable && voltage_detect_in_stop_enable)
          || debug_r) begin
        regulator_state_r <= REG_FULL_ON;
      end else begin
        regulator_state_r <= REG_STANDBY;
      end
    end else if (next_is_lp) begin
      regulator_state_r <= REG_STANDBY;
    end else begin
      regulator_state_r <= REG_FULL_ON;
    end
  end

  // Clock generator and external oscillator in stop modes
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      clock_gen_on_r <= 1'b1;
      ext_osc_on_r <= 1'b1;
    end else begin
      if (mode_nxt == MODE_DEEPEST_STOP_MODE) begin
        clock_gen_on_r <= 1'b0;
      end else if (next_is_shallow_stop_mode) begin
        clock_gen_on_r <= internal_clock_out_enable
                          && internal_ref_stop_enable;
      end else begin
        clock_gen_on_r <= 1'b1;
      end
      if (next_is_stop) begin
        ext_osc_on_r <= external_clock_out_enable
                        && external_ref_stop_enable;
      end else begin
        ext_osc_on_r <= 1'b1;
      end
    end
  end

  // Core, flash and peripheral power; the counter stays powered
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      core_power_on_r <= 1'b1;
      rtc_power_on_r <= 1'b1;
    end else begin
      core_power_on_r <= (mode_nxt != MODE_DEEPEST_STOP_MODE);
      rtc_power_on_r <= 1'b1;
    end
  end

  // Converter permit and bandgap channel block
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      adc_run_permit_r <= 1'b1;
      adc_bandgap_block_r <= 1'b0;
    end else begin
      if (mode_nxt == MODE_DEEPEST_STOP_MODE) begin
        adc_run_permit_r <= 1'b0;
      end else if (next_is_shallow_stop_mode || next_is_lp) begin
        adc_run_permit_r <= adc_async_clock_select;
      end else begin
        adc_run_permit_r <= 1'b1;
      end
      adc_bandgap_block_r <= next_is_lp && adc_bandgap_select;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  a_deep_stop_hold: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (mode_r == MODE_DEEPEST_STOP_MODE) && !pin_reset |=> (mode_r == MODE_DEEPEST_STOP_MODE))
    else $error("deepest stop left without pin reset");

  a_wait_irq_exit: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (mode_r == MODE_WAIT) && interrupt_req |=> (mode_r == MODE_RUN))
    else $error("interrupt did not end normal wait");

  a_deep_stop_entry: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (mode_r == MODE_RUN) && stop_instr && deep_r && !lp_blocked
    && !pin_reset |=> (mode_r == MODE_DEEPEST_STOP_MODE) && !core_power_on_r)
    else $error("deepest stop not entered");

  a_wake_starts_por: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (mode_r == MODE_DEEPEST_STOP_MODE) && pin_reset |=> por_start_r
    && (mode_r == MODE_RUN) ##1 !por_start_r)
    else $error("deepest stop wake did not pulse reset start");

  a_stop_clocks_off: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (mode_r == MODE_DEEPEST_STOP_MODE) || (mode_r == MODE_SHALLOW_STOP_MODE) |->
    (periph_clk_en_one_r == '0) && (periph_clk_en_two_r == '0)
    && !cpu_clk_en_r)
    else $error("clocks running in stop");

  a_monitor_shallow_stop_mode: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (mode_r == MODE_RUN) && stop_instr && voltage_detect_in_stop_enable
    && !pin_reset |=> (mode_r == MODE_SHALLOW_STOP_MODE))
    else $error("monitor enabled but shallow stop not chosen");

  a_debug_no_reduced_power_run_mode: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    debug_r && (mode_r == MODE_RUN) |=> (mode_r != MODE_REDUCED_POWER_RUN_MODE))
    else $error("low-power run entered with debug enabled");

  a_shallow_stop_mode_full_run: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (mode_r == MODE_SHALLOW_STOP_MODE) && interrupt_req && wake_to_full_run_select
    |=> (mode_r == MODE_RUN) && !lpr_r ##1 !low_power_run_state_flag_r)
    else $error("wake-to-run exit kept low-power bits");

  a_bits_exclusive: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    !(lpr_r && deep_r))
    else $error("deep stop and low-power run both set");

  a_deep_from_run: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (mode_r == MODE_DEEPEST_STOP_MODE) && ($past(mode_r) != MODE_DEEPEST_STOP_MODE)
    |-> ($past(mode_r) == MODE_RUN))
    else $error("deepest stop entered from a mode other than run");

  a_bandgap_blocked: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    ((mode_r == MODE_REDUCED_POWER_RUN_MODE) || (mode_r == MODE_REDUCED_POWER_WAIT_MODE))
    && $past(adc_bandgap_select) |-> adc_bandgap_block_r)
    else $error("bandgap channel allowed in low-power mode");

endmodule

`default_nettype wire

// ### rtl/sync_two_stage.sv
`timescale 1ns/1ps
`default_nettype none

// Two flip-flop synchroniser for a level from outside the clock domain
module sync_two_stage
  import pmc_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic async_in,
  output logic sync_out
);

  logic meta_r; // First stage, read only by the second stage

  // Resets to the idle pin level so no false wake is seen
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      meta_r <= PIN_IDLE;
      sync_out <= PIN_IDLE;
    end else begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule

`default_nettype wire

// ### test/core_model.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////
// Core side: turns bench requests into instruction pulses
module core_model (
  input wire logic core_clk,
  input wire logic [1:0] ev_code, // 1 stop, 2 wait, 3 interrupt
  input wire logic ev_go, // Request strobe from the bench
  input wire logic pin_low, // Hold the shared pin low
  output logic stop_instr,
  output logic wait_instr,
  output logic interrupt_req,
  output logic shared_reset_wake_pin_n
);
  // Idle levels from time zero
  initial begin
    stop_instr = 1'h0;
    wait_instr = 1'h0;
    interrupt_req = 1'h0;
    shared_reset_wake_pin_n = 1'h1;
  end
  // One-cycle pulses, launched just after the edge
  always @(posedge core_clk) begin
    stop_instr <= ev_go && (ev_code == 2'h1);
    wait_instr <= ev_go && (ev_code == 2'h2);
    interrupt_req <= ev_go && (ev_code == 2'h3);
    // A low level is the only way out of the deepest stop
    shared_reset_wake_pin_n <= !pin_low;
  end
endmodule
`default_nettype wire

// ### test/power_mode_controller_bench.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////
module power_mode_controller_bench;
  import pmc_pkg::*;
  // Row: config {deep,dbg,vsen,lpr,sel}, two events, three modes
  typedef struct packed {
    logic [4:0] cfg;
    logic [1:0] e1;
    logic [1:0] e2;
    logic [2:0] m0;
    logic [2:0] m1;
    logic [2:0] m2;
  } row_type;
  row_type rows [12];
  row_type r;
  int err_total = 0;
  int tests_run = 0;
  logic got, lb;
  logic core_clk = 1'h0;
  logic reset_n = 1'h0;
  logic [1:0] ev_code = 2'h0;
  logic ev_go = 1'h0;
  logic pin_low = 1'h0;
  logic stop_instr, wait_instr, interrupt_req, shared_reset_wake_pin_n;
  logic lpr_write = 1'h0, lpr_write_data = 1'h0;
  logic deep_stop_write = 1'h0, deep_stop_write_data = 1'h0;
  logic background_debug_port_write = 1'h0;
  logic background_debug_port_data = 1'h0;
  logic wake_to_full_run_select = 1'h0;
  logic voltage_detect_in_stop_enable = 1'h0;
  logic internal_ref_stop_enable = 1'h0, external_ref_stop_enable = 1'h0;
  logic adc_async_clock_select = 1'h1, adc_bandgap_select = 1'h1;
  logic [2:0] mode_code_r;
  logic low_power_run_request_r, low_power_run_state_flag_r;
  logic deep_stop_select_r, debug_mode_enable_r, cpu_clk_en_r;
  logic [GATE_WIDTH-1:0] periph_clk_en_one_r, periph_clk_en_two_r;
  logic debug_clk_en_r, clock_gen_on_r, ext_osc_on_r, core_power_on_r;
  logic [1:0] regulator_state_r;
  logic rtc_power_on_r, por_start_r, adc_run_permit_r, adc_bandgap_block_r;

  // Clock, 50 ns period
  always #25 core_clk = ~core_clk;

  ////////////////////////////////////////
  // Core partner and design
  core_model core (.core_clk, .ev_code, .ev_go, .pin_low, .stop_instr,
    .wait_instr, .interrupt_req, .shared_reset_wake_pin_n);

  power_mode_controller DUT (.core_clk, .reset_n, .stop_instr, .wait_instr,
    .interrupt_req, .shared_reset_wake_pin_n, .lpr_write, .lpr_write_data,
    .deep_stop_write, .deep_stop_write_data, .wake_to_full_run_select,
    .background_debug_port_write, .background_debug_port_data,
    .voltage_detect_enable(1'h1), .voltage_detect_in_stop_enable,
    .internal_clock_out_enable(1'h1), .internal_ref_stop_enable,
    .external_clock_out_enable(1'h1), .external_ref_stop_enable,
    .clock_gating_reg_one(8'h5a), .clock_gating_reg_two(8'h3c),
    .adc_async_clock_select, .adc_bandgap_select, .mode_code_r,
    .low_power_run_request_r, .low_power_run_state_flag_r,
    .deep_stop_select_r, .debug_mode_enable_r, .cpu_clk_en_r,
    .periph_clk_en_one_r, .periph_clk_en_two_r, .debug_clk_en_r,
    .regulator_state_r, .clock_gen_on_r, .ext_osc_on_r, .core_power_on_r,
    .rtc_power_on_r, .por_start_r, .adc_run_permit_r, .adc_bandgap_block_r);

  ////////////////////////////////////////
  // Compare one value, count and report
  task automatic chk(input string nm, input logic [7:0] ex,
                     input logic [7:0] gt);
    tests_run++;
    if (gt !== ex) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, gt);
    end
  endtask

  // Expected outputs of a settled mode, then realign to the edge
  task automatic check(input logic [2:0] m, input logic dbg,
                       input logic vs, input logic lb);
    logic lp;
    logic [1:0] rg;
    logic [7:0] g1, g2;
    logic cg, os, ap, bg;
    #1;
    lp = (m == 3'h2) || (m == 3'h3);
    rg = lp ? REG_STANDBY : REG_FULL_ON;
    if (m == 3'h4) rg = (vs || dbg) ? REG_FULL_ON : REG_STANDBY;
    if (m == 3'h5) rg = REG_PARTIAL_DOWN;
    g1 = m[2] ? 8'h00 : lp ? 8'h5a : 8'hff;
    g2 = m[2] ? 8'h00 : lp ? 8'h3c : 8'hff;
    cg = (m == 3'h5) ? 1'h0 : (m == 3'h4) ? internal_ref_stop_enable : 1'h1;
    os = m[2] ? external_ref_stop_enable : 1'h1;
    ap = (m == 3'h5) ? 1'h0 : (m[2] || lp) ? adc_async_clock_select : 1'h1;
    bg = lp && adc_bandgap_select;
    chk("mode", m, mode_code_r);
    chk("gate1", g1, periph_clk_en_one_r);
    chk("gate2", g2, periph_clk_en_two_r);
    chk("lp_flag", lp, low_power_run_state_flag_r);
    chk("cpu_clk", (m == 3'h0) || (m == 3'h2), cpu_clk_en_r);
    chk("regulator", rg, regulator_state_r);
    chk("clk_gen", cg, clock_gen_on_r);
    chk("osc", os, ext_osc_on_r);
    chk("core_pwr", m != 3'h5, core_power_on_r);
    chk("rtc_pwr", 1'h1, rtc_power_on_r);
    chk("adc_permit", ap, adc_run_permit_r);
    chk("bandgap_blk", bg, adc_bandgap_block_r);
    chk("debug_clk", dbg && (m != 3'h5), debug_clk_en_r);
    chk("lpr_bit", lb, low_power_run_request_r);
    @(posedge core_clk);
  endtask

  // Ask the core for one event and let the mode settle
  task automatic fire(input logic [1:0] e);
    ev_code <= e;
    ev_go <= 1'h1;
    @(posedge core_clk);
    ev_go <= 1'h0;
    repeat (4) @(posedge core_clk);
  endtask

  // Closing report
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  ////////////////////////////////////////
  // Main sequence
  initial begin
    rows = '{'{5'h10, 2'h1, 2'h3, 3'h0, 3'h5, 3'h5},
      '{5'h18, 2'h1, 2'h3, 3'h0, 3'h4, 3'h0},
      '{5'h14, 2'h1, 2'h3, 3'h0, 3'h4, 3'h0},
      '{5'h00, 2'h1, 2'h3, 3'h0, 3'h4, 3'h0},
      '{5'h00, 2'h2, 2'h3, 3'h0, 3'h1, 3'h0},
      '{5'h02, 2'h1, 2'h3, 3'h2, 3'h4, 3'h2},
      '{5'h03, 2'h1, 2'h3, 3'h2, 3'h4, 3'h0},
      '{5'h02, 2'h2, 2'h3, 3'h2, 3'h3, 3'h2},
      '{5'h03, 2'h2, 2'h3, 3'h2, 3'h3, 3'h0},
      '{5'h0a, 2'h2, 2'h3, 3'h0, 3'h1, 3'h0},
      '{5'h06, 2'h2, 2'h3, 3'h0, 3'h1, 3'h0},
      '{5'h12, 2'h1, 2'h3, 3'h0, 3'h5, 3'h5}};
    repeat (5) @(posedge core_clk);
    check(3'h0, 1'h0, 1'h0, 1'h0);
    reset_n <= 1'h1;
    @(posedge core_clk);
    // Table rows, each from a fresh reset
    for (int i = 0; i < 12; i++) begin
      r = rows[i];
      // Low-power run bit expected: refused while deep stop is selected
      lb = r.cfg[1] && !r.cfg[4];
      reset_n <= 1'h0;
      voltage_detect_in_stop_enable <= r.cfg[2];
      wake_to_full_run_select <= r.cfg[0];
      internal_ref_stop_enable <= i[0];
      external_ref_stop_enable <= i[1];
      adc_async_clock_select <= i[2];
      adc_bandgap_select <= !i[0];
      repeat (2) @(posedge core_clk);
      reset_n <= 1'h1;
      deep_stop_write <= 1'h1;
      deep_stop_write_data <= r.cfg[4];
      background_debug_port_write <= 1'h1;
      background_debug_port_data <= r.cfg[3];
      @(posedge core_clk);
      deep_stop_write <= 1'h0;
      background_debug_port_write <= 1'h0;
      // Slow clocking assumed set up; low-power run bit goes last
      lpr_write <= 1'h1;
      lpr_write_data <= r.cfg[1];
      @(posedge core_clk);
      lpr_write <= 1'h0;
      repeat (4) @(posedge core_clk);
      check(r.m0, r.cfg[3], r.cfg[2], lb);
      fire(r.e1);
      check(r.m1, r.cfg[3], r.cfg[2], lb);
      fire(r.e2);
      // Wake-to-run interrupt exits clear the low-power run bit
      lb = lb && !r.cfg[0];
      check(r.m2, r.cfg[3], r.cfg[2], lb);
    end
    // Pin wake from the deepest stop starts a power-on sequence
    pin_low <= 1'h1;
    got = 1'h0;
    for (int k = 0; k < 10 && !got; k++) begin
      @(posedge core_clk);
      #1;
      got = (por_start_r === 1'h1);
    end
    chk("por_start", 1'h1, got);
    if (!got) summarize();
    chk("wake_mode", MODE_RUN, mode_code_r);
    @(posedge core_clk);
    #1;
    chk("por_pulse", 1'h0, por_start_r);
    repeat (2) @(posedge core_clk);
    #1;
    chk("deep_clear", 1'h0, deep_stop_select_r);
    @(posedge core_clk);
    pin_low <= 1'h0;
    background_debug_port_write <= 1'h1;
    background_debug_port_data <= 1'h1;
    @(posedge core_clk);
    background_debug_port_write <= 1'h0;
    repeat (3) @(posedge core_clk);
    #1;
    chk("debug_bit", 1'h1, debug_mode_enable_r);
    // Both select bits written in one cycle: deep stop wins
    @(posedge core_clk);
    deep_stop_write <= 1'h1;
    deep_stop_write_data <= 1'h1;
    lpr_write <= 1'h1;
    lpr_write_data <= 1'h1;
    @(posedge core_clk);
    deep_stop_write <= 1'h0;
    lpr_write <= 1'h0;
    repeat (2) @(posedge core_clk);
    #1;
    chk("deep_wins", 1'h1, deep_stop_select_r);
    chk("lpr_refused", 1'h0, low_power_run_request_r);
    summarize();
  end
endmodule
`default_nettype wire
